/* File: src/ncf_params.svh */
/*
 * Constants of the flag, return and skip execution unit: register offsets,
 * field positions, reset values and instruction codes.
 * Assumes it is included by bare name from the package and the testbench.
 */
`ifndef NCF_PARAMS_SVH
`define NCF_PARAMS_SVH

// Register offsets on the plain register port
`define NCF_REG_STATUS 3'h0
`define NCF_REG_CLEAR 3'h1
`define NCF_REG_ENABLE 3'h2
`define NCF_REG_CTRL 3'h3
`define NCF_REG_STATE 3'h4

// Event bit positions, shared by status, clear and enable
`define NCF_EV_EXT0 0
`define NCF_EV_EXT1 1
`define NCF_EV_CONV 2

// Control and state register fields
`define NCF_CTRL_POL 0
`define NCF_ST_CARRY 0
`define NCF_ST_BANK 1
`define NCF_ST_PORTC 2
`define NCF_ST_SP_LSB 4

// Widths
`define NCF_PC_W 14
`define NCF_SP_W 3
`define NCF_PORTD_W 10
`define NCF_PORTD_MAX 4'h9

// Reset values
`define NCF_RST_PC 14'h0000
`define NCF_RST_FLAGS 3'h0
`define NCF_RST_ENABLE 3'h0

// Instruction codes
`define NCF_OP_RBK 10'h040
`define NCF_OP_SBK 10'h041
`define NCF_OP_RC 10'h006
`define NCF_OP_SC 10'h007
`define NCF_OP_RCP 10'h28c
`define NCF_OP_SCP 10'h28d
`define NCF_OP_RD 10'h014
`define NCF_OP_SD 10'h015
`define NCF_OP_RT 10'h044
`define NCF_OP_RTS 10'h045
`define NCF_OP_RTI 10'h046
`define NCF_OP_SB 10'h05c
`define NCF_OP_SEA 10'h025
`define NCF_OP_SEA2 6'h07
`define NCF_OP_SKIP_IF_ACC_EQ_MEM 10'h026
`define NCF_OP_TEST_EXT0_REQUEST 10'h038
`define NCF_OP_TEST_EXT1_REQUEST 10'h039
`define NCF_OP_TEST_CONVERSION_DONE 10'h287
`define NCF_OP_TEST_EXT0_PIN_LEVEL 10'h03a

`endif

/* File: src/ncf_pkg.sv */
/*
 * Types of the flag, return and skip execution unit.
 * Assumes ncf_params.svh is on the include path.
 */
`include "ncf_params.svh"

package ncf_pkg;

    // Sequencing phase of the unit
    typedef enum logic [1:0] {PH_RUN, PH_WAIT, PH_IMM} ncf_phase_t;

    // Whole state of the unit except the return stack
    typedef struct packed {
        ncf_phase_t phase;
        logic skip;
        logic imm_drop;
        logic carry;
        logic bank;
        logic port_c;
        logic [`NCF_PORTD_W-1:0] port_d;
        logic [`NCF_PC_W-1:0] pc;
        logic [`NCF_SP_W-1:0] sp;
        logic [2:0] flags;
        logic [2:0] int_en;
        logic pol;
        logic [3:0] sv_x;
        logic [3:0] sv_y;
        logic [1:0] sv_z;
        logic [3:0] sv_a;
        logic [3:0] sv_b;
        logic sv_carry;
        logic sv_skip;
        logic sv_nop;
        logic restore;
        logic mem_we;
        logic [3:0] mem_wdata;
        logic [7:0] rdata;
    } ncf_state_t;

endpackage

/* File: src/ncf_exec.sv */
/*
 * Execution unit for bank select, carry, port C and D bits, memory bit set,
 * the three returns, compare skips and event flag skips of a 4-bit core.
 * Assumes fetch offers one word per cycle on a valid/ready pair, that the
 * data memory nibble at the data pointer is presented on i_mem_rdata, and
 * that interrupt entry and calls are signalled by the surrounding core.
 */
// Strobed register access and the register addresses were chosen for this implementation.
// Functional notes
// [RQ1] Bank clear selects lookup pages 0-63
// [RQ2] Bank set selects lookup pages 64-127
// [RQ3] Carry clear: one word, one cycle
// [RQ4] Carry set: one word, one cycle
// [RQ5] Port C cleared or set, one cycle
// [RQ6] Port D bit by Y, 0 to 9
// [RQ7] Plain return pops, two cycles
// [RQ8] Return pops and always skips, two cycles
// [RQ9] Interrupt return pops and restores saved context
// [RQ10] Set memory nibble bit given by immediate
// [RQ11] Two-word compare with immediate skips on equal
// [RQ12] Compare with memory nibble skips on equal
// [RQ13] Ext0 flag test skips, clears; enabled means no-op
// [RQ14] Ext1 flag test skips, clears; enabled means no-op
// [RQ15] Conversion flag test skips, clears; enabled means no-op
// [RQ16] Ext0 pin level test per polarity
// [RQ17] Skipped word has no effect, pc advances
`timescale 1ns/1ps
`default_nettype none

module ncf_exec
    import ncf_pkg::*;
#(
    parameter int STACK_DEPTH = 8 // Return stack entries
)(
    input wire logic i_mclk, // System clock, one machine cycle
    input wire logic i_sys_rst, // Async reset, active high
    input wire logic i_instr_valid, // Fetch offers a word
    input wire logic [9:0] i_instr, // Instruction word
    output logic o_instr_ready, // Unit takes the word this cycle
    input wire logic i_call, // Call: push pc, jump
    input wire logic [`NCF_PC_W-1:0] i_call_target, // Call destination
    input wire logic i_int_entry, // Interrupt entry: push pc, save context
    input wire logic [`NCF_PC_W-1:0] i_int_vector, // Interrupt destination
    input wire logic [3:0] i_acc, // Live register A
    input wire logic [3:0] i_regb, // Live register B
    input wire logic [3:0] i_x, // Live pointer X
    input wire logic [3:0] i_y, // Live pointer Y
    input wire logic [1:0] i_z, // Live pointer Z
    input wire logic i_nop_mode, // Live NOP-mode status
    input wire logic [3:0] i_mem_rdata, // Addressed memory nibble
    input wire logic i_ext0_event, // Ext0 request pulse
    input wire logic i_ext1_event, // Ext1 request pulse
    input wire logic i_conv_event, // Conversion done pulse
    input wire logic i_ext0_pin, // Ext0 pin level
    input wire logic [2:0] i_reg_addr, // Register address
    input wire logic [7:0] i_reg_wdata, // Register write data
    input wire logic i_reg_we, // Register write strobe
    input wire logic i_reg_re, // Register read strobe
    output logic [7:0] o_reg_rdata, // Read data, cycle after strobe
    output logic o_irq, // Level interrupt
    output logic [`NCF_PC_W-1:0] o_pc, // Program counter
    output logic o_page_bank_bit, // Lookup page bank
    output logic o_carry, // Carry flag
    output logic o_port_c, // Port C
    output logic [`NCF_PORTD_W-1:0] o_port_d, // Port D
    output logic o_mem_we, // Memory nibble write pulse
    output logic [3:0] o_mem_wdata, // Memory nibble write data
    output logic o_restore, // Context restore pulse
    output logic [3:0] o_rst_acc, // Restored A
    output logic [3:0] o_rst_regb, // Restored B
    output logic [3:0] o_rst_x, // Restored X
    output logic [3:0] o_rst_y, // Restored Y
    output logic [1:0] o_rst_z, // Restored Z
    output logic o_rst_nop // Restored NOP-mode status
);

    // Stack index must reach every entry
    initial
    begin
        if (STACK_DEPTH < 2 || STACK_DEPTH > (1 << `NCF_SP_W))
            $error("STACK_DEPTH out of range");
    end

    ncf_state_t q; // Registered state
    ncf_state_t d; // Next state
    logic [`NCF_PC_W-1:0] stack_q [STACK_DEPTH]; // Return addresses
    logic push_en; // Stack write this cycle
    logic [`NCF_SP_W-1:0] push_idx; // Stack slot written
    logic [`NCF_PC_W-1:0] push_val; // Address pushed
    logic take; // Word accepted
    logic exec; // Accepted word takes effect
    logic [2:0] flag_clr; // Flags cleared this cycle
    logic [2:0] flag_set; // Flags raised this cycle

    // Flag test: skip when the flag is up and its interrupt is off
    function automatic logic flag_skip(input logic flag, input logic en);
        flag_skip = flag && !en;
    endfunction

    // Ready drops during return second cycle and on entry or call
    assign o_instr_ready = (q.phase != PH_WAIT) && !i_int_entry && !i_call;
    assign take = i_instr_valid && o_instr_ready;
    assign exec = take && (q.phase == PH_RUN) && !q.skip;

    // Next state of the whole unit
    always_comb
    begin
        d = q;
        d.mem_we = 1'b0;
        d.restore = 1'b0;
        push_en = 1'b0;
        push_idx = q.sp + `NCF_SP_W'(1);
        push_val = q.pc;
        flag_clr = 3'h0;
        flag_set = {i_conv_event, i_ext1_event, i_ext0_event};
        if (q.phase == PH_WAIT)
        begin
            // Second machine cycle of a return
            d.phase = PH_RUN;
        end
        if (i_int_entry)
        begin
            // Entry takes priority; fetched word waits
            push_en = 1'b1;
            d.sp = push_idx;
            d.pc = i_int_vector;
            d.sv_x = i_x;
            d.sv_y = i_y;
            d.sv_z = i_z;
            d.sv_a = i_acc;
            d.sv_b = i_regb;
            d.sv_carry = q.carry;
            d.sv_skip = q.skip;
            d.sv_nop = i_nop_mode;
            d.skip = 1'b0;
        end
        else if (i_call)
        begin
            push_en = 1'b1;
            d.sp = push_idx;
            d.pc = i_call_target;
        end
        else if (take)
        begin
            d.pc = q.pc + `NCF_PC_W'(1);
            if (q.phase == PH_IMM)
            begin
                // Second word carries the immediate
                d.phase = PH_RUN;
                d.imm_drop = 1'b0;
                if (!q.imm_drop && i_instr[9:4] == `NCF_OP_SEA2 && i_instr[3:0] == i_acc)
                    d.skip = 1'b1; // [RQ11]
            end
            else if (q.skip)
            begin
                // Suppressed word: only the pc moves [RQ17]
                d.skip = 1'b0;
                if (i_instr == `NCF_OP_SEA)
                begin
                    // Drop the trailing immediate as well
                    d.phase = PH_IMM;
                    d.imm_drop = 1'b1;
                end
            end
            else if (i_instr[9:2] == `NCF_OP_SB >> 2)
            begin
                d.mem_we = 1'b1; // [RQ10]
                d.mem_wdata = i_mem_rdata | (4'h1 << i_instr[1:0]); // [RQ10]
            end
            else
            begin
                unique case (i_instr)
                    `NCF_OP_RBK: d.bank = 1'b0; // [RQ1]
                    `NCF_OP_SBK: d.bank = 1'b1; // [RQ2]
                    `NCF_OP_RC: d.carry = 1'b0; // [RQ3]
                    `NCF_OP_SC: d.carry = 1'b1; // [RQ4]
                    `NCF_OP_RCP: d.port_c = 1'b0; // [RQ5]
                    `NCF_OP_SCP: d.port_c = 1'b1; // [RQ5]
                    `NCF_OP_RD:
                    begin
                        // Y above 9 has no port bit and is ignored
                        if (i_y <= `NCF_PORTD_MAX)
                            d.port_d[i_y] = 1'b0; // [RQ6]
                    end
                    `NCF_OP_SD:
                    begin
                        if (i_y <= `NCF_PORTD_MAX)
                            d.port_d[i_y] = 1'b1; // [RQ6]
                    end
                    `NCF_OP_RT:
                    begin
                        d.pc = stack_q[q.sp]; // [RQ7]
                        d.sp = q.sp - `NCF_SP_W'(1); // [RQ7]
                        d.phase = PH_WAIT; // [RQ7]
                    end
                    `NCF_OP_RTS:
                    begin
                        d.pc = stack_q[q.sp]; // [RQ8]
                        d.sp = q.sp - `NCF_SP_W'(1); // [RQ8]
                        d.phase = PH_WAIT; // [RQ8]
                        d.skip = 1'b1; // [RQ8]
                    end
                    `NCF_OP_RTI:
                    begin
                        // Single cycle; core reloads from the restore pins
                        d.pc = stack_q[q.sp]; // [RQ9]
                        d.sp = q.sp - `NCF_SP_W'(1); // [RQ9]
                        d.carry = q.sv_carry; // [RQ9]
                        d.skip = q.sv_skip; // [RQ9]
                        d.restore = 1'b1; // [RQ9]
                    end
                    `NCF_OP_SEA:
                    begin
                        d.phase = PH_IMM; // [RQ11]
                        d.imm_drop = 1'b0;
                    end
                    `NCF_OP_SKIP_IF_ACC_EQ_MEM: d.skip = (i_acc == i_mem_rdata); // [RQ12]
                    `NCF_OP_TEST_EXT0_REQUEST:
                    begin
                        d.skip = flag_skip(q.flags[`NCF_EV_EXT0], q.int_en[`NCF_EV_EXT0]); // [RQ13]
                        flag_clr[`NCF_EV_EXT0] = d.skip; // [RQ13]
                    end
                    `NCF_OP_TEST_EXT1_REQUEST:
                    begin
                        d.skip = flag_skip(q.flags[`NCF_EV_EXT1], q.int_en[`NCF_EV_EXT1]); // [RQ14]
                        flag_clr[`NCF_EV_EXT1] = d.skip; // [RQ14]
                    end
                    `NCF_OP_TEST_CONVERSION_DONE:
                    begin
                        d.skip = flag_skip(q.flags[`NCF_EV_CONV], q.int_en[`NCF_EV_CONV]); // [RQ15]
                        flag_clr[`NCF_EV_CONV] = d.skip; // [RQ15]
                    end
                    `NCF_OP_TEST_EXT0_PIN_LEVEL: d.skip = (i_ext0_pin == q.pol); // [RQ16]
                    default: d.skip = 1'b0; // Other words belong elsewhere
                endcase
            end
        end
        // Register writes; software clear of a status bit
        if (i_reg_we)
        begin
            unique case (i_reg_addr)
                `NCF_REG_CLEAR: flag_clr = flag_clr | i_reg_wdata[2:0];
                `NCF_REG_ENABLE: d.int_en = i_reg_wdata[2:0];
                `NCF_REG_CTRL: d.pol = i_reg_wdata[`NCF_CTRL_POL];
                default: d.pol = d.pol; // Read-only or unmapped: ignored
            endcase
        end
        // A new event beats a clear in the same cycle
        d.flags = (q.flags & ~flag_clr) | flag_set;
        // Read data stands in the cycle after the strobe only
        d.rdata = 8'h00;
        if (i_reg_re)
        begin
            unique case (i_reg_addr)
                `NCF_REG_STATUS: d.rdata = {5'h00, q.flags};
                `NCF_REG_ENABLE: d.rdata = {5'h00, q.int_en};
                `NCF_REG_CTRL: d.rdata = {7'h00, q.pol};
                `NCF_REG_STATE: d.rdata = {1'b0, q.sp, 1'b0, q.port_c, q.bank, q.carry};
                default: d.rdata = 8'h00; // Clear register and holes read zero
            endcase
        end
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            q <= '0;
            q.pc <= `NCF_RST_PC;
            q.flags <= `NCF_RST_FLAGS;
            q.int_en <= `NCF_RST_ENABLE;
        end
        else
        begin
            q <= d;
        end
    end

    // Return stack; contents need no reset, the index guards them
    always_ff @(posedge i_mclk)
    begin
        if (push_en)
            stack_q[push_idx] <= push_val;
    end

    assign o_reg_rdata = q.rdata;
    assign o_irq = |(q.flags & q.int_en);
    assign o_pc = q.pc;
    assign o_page_bank_bit = q.bank;
    assign o_carry = q.carry;
    assign o_port_c = q.port_c;
    assign o_port_d = q.port_d;
    assign o_mem_we = q.mem_we;
    assign o_mem_wdata = q.mem_wdata;
    assign o_restore = q.restore;
    assign o_rst_acc = q.sv_a;
    assign o_rst_regb = q.sv_b;
    assign o_rst_x = q.sv_x;
    assign o_rst_y = q.sv_y;
    assign o_rst_z = q.sv_z;
    assign o_rst_nop = q.sv_nop;

    // Checks of the execution behaviour
    property p_bank_clr; // [RQ1]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_RBK |=> !o_page_bank_bit;
    endproperty
    a_bank_clr: assert property (p_bank_clr) else $error("bank not cleared"); // [RQ1]

    property p_bank_set; // [RQ2]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_SBK |=> o_page_bank_bit && !q.skip;
    endproperty
    a_bank_set: assert property (p_bank_set) else $error("bank not set"); // [RQ2]

    property p_carry_clr; // [RQ3]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_RC |=> !o_carry && o_instr_ready && $stable(o_port_d);
    endproperty
    a_carry_clr: assert property (p_carry_clr) else $error("carry clear wrong"); // [RQ3]

    property p_carry_set; // [RQ4]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_SC |=> o_carry && !q.skip && o_instr_ready;
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry set wrong"); // [RQ4]

    property p_port_c; // [RQ5]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && (i_instr == `NCF_OP_RCP || i_instr == `NCF_OP_SCP)
        |=> o_port_c == $past(i_instr[0]);
    endproperty
    a_port_c: assert property (p_port_c) else $error("port C wrong"); // [RQ5]

    property p_port_d; // [RQ6]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_SD && i_y <= `NCF_PORTD_MAX |=> o_port_d[$past(i_y)];
    endproperty
    a_port_d: assert property (p_port_d) else $error("port D bit not set"); // [RQ6]

    property p_ret_plain; // [RQ7]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_RT
        |=> !o_instr_ready && q.sp == $past(q.sp) - `NCF_SP_W'(1);
    endproperty
    a_ret_plain: assert property (p_ret_plain) else $error("return timing wrong"); // [RQ7]

    property p_ret_skip; // [RQ8]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_RTS |=> q.skip && q.phase == PH_WAIT ##1 q.phase == PH_RUN;
    endproperty
    a_ret_skip: assert property (p_ret_skip) else $error("return skip wrong"); // [RQ8]

    property p_ret_int; // [RQ9]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_RTI |=> o_restore && o_carry == q.sv_carry ##1 !o_restore;
    endproperty
    a_ret_int: assert property (p_ret_int) else $error("interrupt return wrong"); // [RQ9]

    property p_set_bit; // [RQ10]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr[9:2] == `NCF_OP_SB >> 2
        |=> o_mem_we && o_mem_wdata == ($past(i_mem_rdata) | (4'h1 << $past(i_instr[1:0])));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("memory bit wrong"); // [RQ10]

    property p_cmp_imm; // [RQ11]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_SEA ##1 take && i_instr[9:4] == `NCF_OP_SEA2
        |=> q.skip == ($past(i_instr[3:0]) == $past(i_acc));
    endproperty
    a_cmp_imm: assert property (p_cmp_imm) else $error("immediate compare wrong"); // [RQ11]

    property p_cmp_mem; // [RQ12]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_SKIP_IF_ACC_EQ_MEM |=> q.skip == ($past(i_acc) == $past(i_mem_rdata));
    endproperty
    a_cmp_mem: assert property (p_cmp_mem) else $error("memory compare wrong"); // [RQ12]

    property p_ext0; // [RQ13]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_TEST_EXT0_REQUEST && !i_ext0_event
        |=> q.skip == $past(q.flags[0] && !q.int_en[0]) && (!q.skip || !q.flags[0]);
    endproperty
    a_ext0: assert property (p_ext0) else $error("ext0 test wrong"); // [RQ13]

    property p_ext1; // [RQ14]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_TEST_EXT1_REQUEST && q.int_en[`NCF_EV_EXT1] |=> !q.skip;
    endproperty
    a_ext1: assert property (p_ext1) else $error("ext1 no-op wrong"); // [RQ14]

    property p_conv; // [RQ15]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_TEST_CONVERSION_DONE && q.flags[2] && !q.int_en[2] && !i_conv_event
        |=> q.skip && !q.flags[`NCF_EV_CONV];
    endproperty
    a_conv: assert property (p_conv) else $error("conversion test wrong"); // [RQ15]

    property p_pin; // [RQ16]
        @(posedge i_mclk) disable iff (i_sys_rst)
        exec && i_instr == `NCF_OP_TEST_EXT0_PIN_LEVEL |=> q.skip == ($past(i_ext0_pin) == $past(q.pol));
    endproperty
    a_pin: assert property (p_pin) else $error("pin test wrong"); // [RQ16]

    property p_suppress; // [RQ17]
        @(posedge i_mclk) disable iff (i_sys_rst)
        take && q.skip && q.phase == PH_RUN && !i_int_entry && !i_call
        |=> o_pc == $past(o_pc) + `NCF_PC_W'(1) && !o_mem_we && !o_restore && $stable(o_carry);
    endproperty
    a_suppress: assert property (p_suppress) else $error("skipped word took effect"); // [RQ17]

endmodule

`default_nettype wire

/* File: testbench/ncf_exec_tb.sv */
/*
 * Self-checking bench for the flag, return and skip execution unit.
 * Assumes ncf_pkg and ncf_params.svh are compiled ahead of this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ncf_params.svh"

module testbench
    import ncf_pkg::*;
;
    logic i_mclk = 1'b0; // 10 MHz system clock
    logic i_sys_rst = 1'b1; // Reset, held at start
    logic vld = 1'b0; // Instruction valid
    logic [9:0] ins = 10'h000; // Instruction word
    logic call = 1'b0; // Call pulse
    logic ient = 1'b0; // Interrupt entry pulse
    logic [3:0] acc = 4'h0; // Live A, also feeds B and X
    logic [3:0] yreg = 4'h0; // Live Y
    logic [3:0] mem = 4'h0; // Addressed memory nibble
    logic pin = 1'b0; // Ext0 pin level
    logic [2:0] ev = 3'h0; // Event pulses
    logic [2:0] ra = 3'h0; // Register address
    logic [7:0] rw = 8'h00; // Register write data
    logic we = 1'b0; // Register write strobe
    logic re = 1'b0; // Register read strobe
    logic [7:0] rdata; // Read data
    logic irq, bank, carry, portc, mwe, rstr, rnop; // Single-bit outputs
    logic [13:0] pc; // Program counter
    logic [9:0] portd; // Port D
    logic [3:0] mwd, racc, rb, rx, ry; // Nibble outputs
    logic [1:0] rz; // Restored Z
    logic rdy; // Instruction ready
    int n_tests = 0; // Comparisons made
    int n_errors = 0; // Mismatches seen
    logic [9:0] seq [6] = '{`NCF_OP_SBK, `NCF_OP_SC, `NCF_OP_SCP, `NCF_OP_RBK,
        `NCF_OP_RC, `NCF_OP_RCP}; // Flag walk
    logic [2:0] st [6] = '{3'h2, 3'h3, 3'h7, 3'h5, 3'h4, 3'h0}; // {port C, bank, carry}
    logic [9:0] tst [3] = '{`NCF_OP_TEST_EXT0_REQUEST, `NCF_OP_TEST_EXT1_REQUEST, `NCF_OP_TEST_CONVERSION_DONE}; // Flag tests
    logic [9:0] pd; // Expected port D
    logic [13:0] p; // Saved pc

    // Free-running clock, 100 ns period
    always #50 i_mclk = ~i_mclk;

    ncf_exec u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_instr_valid(vld),
        .i_instr(ins), .o_instr_ready(rdy), .i_call(call), .i_call_target(14'h0100),
        .i_int_entry(ient), .i_int_vector(14'h0200), .i_acc(acc), .i_regb(acc),
        .i_x(acc), .i_y(yreg), .i_z(acc[1:0]), .i_nop_mode(acc[0]), .i_mem_rdata(mem),
        .i_ext0_event(ev[0]), .i_ext1_event(ev[1]), .i_conv_event(ev[2]),
        .i_ext0_pin(pin), .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_we(we),
        .i_reg_re(re), .o_reg_rdata(rdata), .o_irq(irq), .o_pc(pc),
        .o_page_bank_bit(bank), .o_carry(carry), .o_port_c(portc), .o_port_d(portd),
        .o_mem_we(mwe), .o_mem_wdata(mwd), .o_restore(rstr), .o_rst_acc(racc),
        .o_rst_regb(rb), .o_rst_x(rx), .o_rst_y(ry), .o_rst_z(rz), .o_rst_nop(rnop));

    // Compare and count; case inequality so unknowns fail
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One word taken, then an idle cycle; returns at the settled negedge
    task automatic op(input logic [9:0] w);
        @(posedge i_mclk);
        vld <= 1'b1;
        ins <= w;
        @(posedge i_mclk);
        vld <= 1'b0;
        @(negedge i_mclk);
    endtask

    // Core-side live values, changed at an edge
    task automatic setc(input logic [3:0] a, input logic [3:0] m, input logic [3:0] y,
        input logic pn);
        @(posedge i_mclk);
        acc <= a;
        mem <= m;
        yreg <= y;
        pin <= pn;
    endtask

    // One-cycle pulse on {events, entry, call}
    task automatic strobe(input logic [4:0] m);
        @(posedge i_mclk);
        {ev, ient, call} <= m;
        @(posedge i_mclk);
        {ev, ient, call} <= 5'h00;
        @(negedge i_mclk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        we <= 1'b1;
        ra <= a;
        rw <= d;
        @(posedge i_mclk);
        we <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        re <= 1'b1;
        ra <= a;
        @(posedge i_mclk);
        re <= 1'b0;
        @(negedge i_mclk);
        chk(16'(rdata), 16'(exp));
    endtask

    // Skip probe: a carry set right behind the tested word shows the skip
    task automatic sk(input logic [9:0] w0, input logic [9:0] w, input logic s);
        logic [13:0] q;
        op(`NCF_OP_RC);
        q = pc;
        if (w0 !== 10'h000)
            op(w0);
        op(w);
        op(`NCF_OP_SC);
        chk(16'(carry), 16'(!s));
        chk(16'(pc), 16'(q + ((w0 !== 10'h000) ? 14'h3 : 14'h2)));
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog; the whole sequence needs well under 1500 cycles
    initial
    begin
        #(3000 * 100);
        n_errors++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(3'h4, 8'h00);
        rd(3'h5, 8'h00);
        foreach (seq[i])
        begin
            p = pc;
            op(seq[i]);
            chk(16'({portc, bank, carry, pc}), 16'({st[i], p + 14'h1}));
        end
        $display("flag walk done");
        pd = 10'h000;
        for (int k = 0; k < 22; k++)
        begin
            setc(4'h0, 4'h0, 4'(k % 11), 1'b0);
            op(k < 11 ? `NCF_OP_SD : `NCF_OP_RD);
            if (k % 11 < 10)
                pd[k % 11] = (k < 11);
            chk(16'(portd), 16'(pd));
        end
        setc(4'h0, 4'ha, 4'h0, 1'b0);
        for (int j = 0; j < 4; j++)
        begin
            op(`NCF_OP_SB + 10'(j));
            chk(16'({mwe, mwd}), 16'({1'b1, 4'ha | (4'h1 << j)}));
        end
        $display("port and bit tests done");
        setc(4'h5, 4'h5, 4'h0, 1'b0);
        sk(10'h000, `NCF_OP_SKIP_IF_ACC_EQ_MEM, 1'b1);
        setc(4'h5, 4'h6, 4'h0, 1'b0);
        sk(10'h000, `NCF_OP_SKIP_IF_ACC_EQ_MEM, 1'b0);
        sk(`NCF_OP_SEA, 10'h075, 1'b1);
        sk(`NCF_OP_SEA, 10'h076, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            strobe({3'(1 << i), 2'b00});
            rd(3'h0, 8'(1 << i));
            sk(10'h000, tst[i], 1'b1);
            rd(3'h0, 8'h00);
            wr(3'h2, 8'(1 << i));
            strobe({3'(1 << i), 2'b00});
            chk(16'(irq), 16'h1);
            sk(10'h000, tst[i], 1'b0);
            rd(3'h0, 8'(1 << i));
            wr(3'h1, 8'(1 << i));
            rd(3'h0, 8'h00);
            chk(16'(irq), 16'h0);
            wr(3'h2, 8'h00);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(3'h3, 8'(k / 2));
            setc(4'h5, 4'h6, 4'h0, 1'(k % 2));
            sk(10'h000, `NCF_OP_TEST_EXT0_PIN_LEVEL, 1'(k / 2) == 1'(k % 2));
        end
        $display("skip tests done");
        p = pc;
        strobe(5'h01);
        chk(16'(pc), 16'h0100);
        op(`NCF_OP_RT);
        chk(16'(rdy), 16'h0);
        chk(16'(pc), 16'(p));
        op(`NCF_OP_RC);
        p = pc;
        strobe(5'h01);
        op(`NCF_OP_RTS);
        op(`NCF_OP_SC);
        chk(16'({carry, pc}), 16'({1'b0, p + 14'h1}));
        op(`NCF_OP_SC);
        setc(4'h9, 4'h0, 4'h7, 1'b0);
        p = pc;
        strobe(5'h02);
        setc(4'h2, 4'h0, 4'h3, 1'b0);
        op(`NCF_OP_RC);
        op(`NCF_OP_RTI);
        chk(16'({rstr, carry, pc}), 16'({2'b11, p}));
        chk(16'({racc, rb, rx, ry}), 16'h9997);
        chk(16'({rz, rnop}), 16'h3);
        $display("return tests done");
        end_sim();
    end
endmodule

`default_nettype wire
